// ==== src/fhb_blend_unit.sv ====
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module fhb_blend_unit (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Register port.
    input wire logic [5:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [31:0] regRdData,
    // Fragment input.
    input wire logic fragValid,
    output logic fragReady,
    input wire logic signed [15:0] fragRed,
    input wire logic signed [15:0] fragGreen,
    input wire logic signed [15:0] fragBlue,
    input wire logic signed [15:0] fragAlpha,
    input wire logic [15:0] fragIndex,
    input wire logic signed [31:0] fragEyeZ,
    input wire logic signed [31:0] fragHazeCoord,
    input wire logic [12:0] fragVertexFactor,
    input wire logic fragUseVertexFactor,
    // Pipeline mode inputs.
    input wire logic geomShaderActive,
    input wire logic fragShaderActive,
    input wire logic indexMode,
    input wire logic colorClampEnable,
    // Fragment output.
    output logic outValid,
    output logic signed [15:0] outRed,
    output logic signed [15:0] outGreen,
    output logic signed [15:0] outBlue,
    output logic signed [15:0] outAlpha,
    output logic [15:0] outIndex
);
    // Clamp a Q4.12 value into the unit range; used on the RGB blend paths when colorClampEnable is set.
    function automatic logic signed [15:0] clampUnit(input logic signed [15:0] v);
        logic signed [15:0] r;
        r = v;
        if (v < 0) begin
            r = '0;
        end else if (v > fhb_pkg::COLOR_ONE) begin
            r = fhb_pkg::COLOR_ONE;
        end
        return r;
    endfunction

    // Converts a normalised 8-bit integer to Q4.12: c * 4096 / 255, rounded.
    function automatic logic signed [15:0] convertColor(input logic [31:0] w);
        logic [16:0] scaled;
        scaled = 17'({w[7:0], w[7:0]}) + 17'h0_0008;
        return w[fhb_pkg::COLOR_INT_FLAG_BIT] ? $signed(scaled[16:1] >> 3) : $signed(w[15:0]);
    endfunction

    // Configuration registers.
    logic enable_q;
    logic enable_d;
    logic source_q;
    logic source_d;
    fhb_pkg::fhb_equation_t equation_q;
    fhb_pkg::fhb_equation_t equation_d;
    logic signed [31:0] density_q;
    logic signed [31:0] density_d;
    logic signed [31:0] hazeStart_q;
    logic signed [31:0] hazeStart_d;
    logic signed [31:0] hazeEnd_q;
    logic signed [31:0] hazeEnd_d;
    logic signed [15:0] hazeColor_q [4];
    logic signed [15:0] hazeColor_d [4];
    logic [15:0] hazeIndex_q;
    logic [15:0] hazeIndex_d;
    logic errorFlag_q;
    logic errorFlag_d;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;

    // Pipeline registers.
    logic s1Valid_q;
    logic s1Valid_d;
    logic s1Bypass_q;
    logic s1Bypass_d;
    logic signed [31:0] s1Coord_q;
    logic signed [31:0] s1Coord_d;
    logic s1UseVertexF_q;
    logic s1UseVertexF_d;
    logic [12:0] s1VertexF_q;
    logic [12:0] s1VertexF_d;
    logic signed [15:0] s1Color_q [4];
    logic signed [15:0] s1Color_d [4];
    logic [15:0] s1Index_q;
    logic [15:0] s1Index_d;
    logic s2Valid_q;
    logic s2Valid_d;
    logic s2Bypass_q;
    logic s2Bypass_d;
    logic [12:0] s2F_q;
    logic [12:0] s2F_d;
    logic signed [15:0] s2Color_q [4];
    logic signed [15:0] s2Color_d [4];
    logic [15:0] s2Index_q;
    logic [15:0] s2Index_d;
    logic outValid_q;
    logic outValid_d;
    logic signed [15:0] outColor_q [4];
    logic signed [15:0] outColor_d [4];
    logic [15:0] outIndex_q;
    logic [15:0] outIndex_d;
    logic ready_q;

    logic [12:0] calcF;
    logic signed [15:0] blended [3];
    logic [15:0] hazeTerm;
    logic [15:0] indexSum;

    // Register writes and reads.
    always_comb begin
        enable_d = enable_q;
        source_d = source_q;
        equation_d = equation_q;
        density_d = density_q;
        hazeStart_d = hazeStart_q;
        hazeEnd_d = hazeEnd_q;
        hazeColor_d = hazeColor_q;
        hazeIndex_d = hazeIndex_q;
        errorFlag_d = errorFlag_q;
        rdData_d = '0;
        if (regWrStrobe) begin
            unique case (regAddr)
                fhb_pkg::REG_CTRL: begin
                    enable_d = regWrData[fhb_pkg::CTRL_ENABLE_BIT];
                    source_d = regWrData[fhb_pkg::CTRL_SOURCE_BIT];
                end
                fhb_pkg::REG_EQUATION: begin
                    // An unknown code leaves the equation alone and flags it.
                    if (regWrData[1:0] == 2'(fhb_pkg::EQ_DECAY_SINGLE) ||
                        regWrData[1:0] == 2'(fhb_pkg::EQ_DECAY_SQUARED) ||
                        regWrData[1:0] == 2'(fhb_pkg::EQ_RAMP_FALLOFF)) begin
                        equation_d = fhb_pkg::fhb_equation_t'(regWrData[1:0]);
                    end else begin
                        errorFlag_d = 1'b1;
                    end
                end
                fhb_pkg::REG_DENSITY: begin
                    if (regWrData[31]) begin
                        errorFlag_d = 1'b1;
                    end else begin
                        density_d = $signed(regWrData);
                    end
                end
                fhb_pkg::REG_START: hazeStart_d = $signed(regWrData);
                fhb_pkg::REG_END: hazeEnd_d = $signed(regWrData);
                fhb_pkg::REG_COLOR_R: hazeColor_d[0] = convertColor(regWrData);
                fhb_pkg::REG_COLOR_G: hazeColor_d[1] = convertColor(regWrData);
                fhb_pkg::REG_COLOR_B: hazeColor_d[2] = convertColor(regWrData);
                fhb_pkg::REG_COLOR_A: hazeColor_d[3] = convertColor(regWrData);
                fhb_pkg::REG_INDEX: hazeIndex_d = regWrData[15:0] & fhb_pkg::IDX_INT_MASK;
                fhb_pkg::REG_STATUS: begin
                    if (regWrData[fhb_pkg::STAT_ERROR_BIT]) begin
                        errorFlag_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (regRdStrobe) begin
            unique case (regAddr)
                fhb_pkg::REG_CTRL: begin
                    rdData_d[fhb_pkg::CTRL_ENABLE_BIT] = enable_q;
                    rdData_d[fhb_pkg::CTRL_SOURCE_BIT] = source_q;
                end
                fhb_pkg::REG_EQUATION: rdData_d[1:0] = equation_q;
                fhb_pkg::REG_DENSITY: rdData_d = density_q;
                fhb_pkg::REG_START: rdData_d = hazeStart_q;
                fhb_pkg::REG_END: rdData_d = hazeEnd_q;
                fhb_pkg::REG_COLOR_R: rdData_d = 32'(hazeColor_q[0]);
                fhb_pkg::REG_COLOR_G: rdData_d = 32'(hazeColor_q[1]);
                fhb_pkg::REG_COLOR_B: rdData_d = 32'(hazeColor_q[2]);
                fhb_pkg::REG_COLOR_A: rdData_d = 32'(hazeColor_q[3]);
                fhb_pkg::REG_INDEX: rdData_d[15:0] = hazeIndex_q;
                fhb_pkg::REG_STATUS: begin
                    rdData_d[fhb_pkg::STAT_ERROR_BIT] = errorFlag_q;
                    rdData_d[fhb_pkg::STAT_BUSY_BIT] = s1Valid_q | s2Valid_q | outValid_q;
                end
                default: rdData_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_q <= 1'b0;
            source_q <= fhb_pkg::SRC_EYE_DISTANCE;
            equation_q <= fhb_pkg::EQ_DECAY_SINGLE;
            density_q <= fhb_pkg::PARAM_ONE;
            hazeStart_q <= fhb_pkg::PARAM_ZERO;
            hazeEnd_q <= fhb_pkg::PARAM_ONE;
            hazeColor_q <= '{default: '0};
            hazeIndex_q <= '0;
            errorFlag_q <= 1'b0;
            rdData_q <= '0;
        end else begin
            enable_q <= enable_d;
            source_q <= source_d;
            equation_q <= equation_d;
            density_q <= density_d;
            hazeStart_q <= hazeStart_d;
            hazeEnd_q <= hazeEnd_d;
            hazeColor_q <= hazeColor_d;
            hazeIndex_q <= hazeIndex_d;
            errorFlag_q <= errorFlag_d;
            rdData_q <= rdData_d;
        end
    end

    fhb_factor_calc factorCalc (
        .equation(equation_q),
        .density(density_q),
        .hazeStart(hazeStart_q),
        .hazeEnd(hazeEnd_q),
        .coord(s1Coord_q),
        .factor(calcF)
    );

    // Colour blend, one lane per RGB component; alpha is carried separately.
    genvar lane;
    generate
        for (lane = 0; lane < 3; lane++) begin : gLane
            logic signed [15:0] fragC;
            logic signed [15:0] hazeC;
            logic signed [31:0] mix;
            logic signed [31:0] mixQ;
            always_comb begin
                fragC = colorClampEnable ? clampUnit(s2Color_q[lane]) : s2Color_q[lane];
                hazeC = colorClampEnable ? clampUnit(hazeColor_q[lane]) : hazeColor_q[lane];
                mix = $signed({19'h0_0000, s2F_q}) * fragC +
                      $signed({19'h0_0000, fhb_pkg::F_ONE - s2F_q}) * hazeC;
                mixQ = mix >>> fhb_pkg::F_FRAC;
                blended[lane] = colorClampEnable ? clampUnit(mixQ[15:0]) : mixQ[15:0];
            end
        end
    endgenerate

    // Index blend: fragment index plus (1 - f) * haze index rounded to the index fraction bits.
    always_comb begin
        logic [28:0] idxProd;
        idxProd = 29'(fhb_pkg::F_ONE - s2F_q) * 29'(hazeIndex_q) + 29'(fhb_pkg::F_HALF);
        hazeTerm = idxProd[27:12];
        indexSum = s2Index_q + hazeTerm;
    end

    // The stage never stalls; ready rises on the first edge after reset is released, so the upstream side sees it from the second.
    always_comb begin
        s1Valid_d = fragValid & ready_q;
        // Fragment shading overrides the enable bit.
        s1Bypass_d = fragShaderActive | ~enable_q;
        if (geomShaderActive || source_q == fhb_pkg::SRC_HAZE_COORD) begin
            s1Coord_d = fragHazeCoord;
        end else begin
            s1Coord_d = (fragEyeZ < 0) ? -fragEyeZ : fragEyeZ;
        end
        s1UseVertexF_d = fragUseVertexFactor;
        s1VertexF_d = fragVertexFactor;
        s1Color_d = '{fragRed, fragGreen, fragBlue, fragAlpha};
        s1Index_d = fragIndex;

        s2Valid_d = s1Valid_q;
        s2Bypass_d = s1Bypass_q;
        // A per-vertex factor has been interpolated upstream; it is still clamped here.
        if (s1UseVertexF_q) begin
            s2F_d = (s1VertexF_q > fhb_pkg::F_ONE) ? fhb_pkg::F_ONE : s1VertexF_q;
        end else begin
            s2F_d = calcF;
        end
        s2Color_d = s1Color_q;
        s2Index_d = s1Index_q;

        outValid_d = s2Valid_q;
        outColor_d = s2Color_q;
        outIndex_d = s2Index_q;
        if (!s2Bypass_q) begin
            if (indexMode) begin
                outIndex_d = indexSum & fhb_pkg::IDX_INT_MASK;
            end else begin
                outColor_d[0] = blended[0];
                outColor_d[1] = blended[1];
                outColor_d[2] = blended[2];
                outColor_d[3] = s2Color_q[3];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ready_q <= 1'b0;
            s1Valid_q <= 1'b0;
            s1Bypass_q <= 1'b1;
            s1Coord_q <= '0;
            s1UseVertexF_q <= 1'b0;
            s1VertexF_q <= '0;
            s1Color_q <= '{default: '0};
            s1Index_q <= '0;
            s2Valid_q <= 1'b0;
            s2Bypass_q <= 1'b1;
            s2F_q <= '0;
            s2Color_q <= '{default: '0};
            s2Index_q <= '0;
            outValid_q <= 1'b0;
            outColor_q <= '{default: '0};
            outIndex_q <= '0;
        end else begin
            ready_q <= 1'b1;
            s1Valid_q <= s1Valid_d;
            s1Bypass_q <= s1Bypass_d;
            s1Coord_q <= s1Coord_d;
            s1UseVertexF_q <= s1UseVertexF_d;
            s1VertexF_q <= s1VertexF_d;
            s1Color_q <= s1Color_d;
            s1Index_q <= s1Index_d;
            s2Valid_q <= s2Valid_d;
            s2Bypass_q <= s2Bypass_d;
            s2F_q <= s2F_d;
            s2Color_q <= s2Color_d;
            s2Index_q <= s2Index_d;
            outValid_q <= outValid_d;
            outColor_q <= outColor_d;
            outIndex_q <= outIndex_d;
        end
    end

    assign regRdData = rdData_q;
    assign fragReady = ready_q;
    assign outValid = outValid_q;
    assign outRed = outColor_q[0];
    assign outGreen = outColor_q[1];
    assign outBlue = outColor_q[2];
    assign outAlpha = outColor_q[3];
    assign outIndex = outIndex_q;
endmodule

// ==== src/fhb_factor_calc.sv ====
`timescale 1ns/100ps
module fhb_factor_calc (
    // Selection.
    input wire fhb_pkg::fhb_equation_t equation,
    // Parameters and coordinate, Q16.16.
    input wire logic signed [31:0] density,
    input wire logic signed [31:0] hazeStart,
    input wire logic signed [31:0] hazeEnd,
    input wire logic signed [31:0] coord,
    // Clamped factor.
    output logic [12:0] factor
);
    // Fraction table of 2^-(i/16), Q1.12.
    function automatic logic [12:0] pow2Frac(input logic [3:0] i);
        logic [12:0] t;
        unique case (i)
            4'h0: t = 13'h1000;
            4'h1: t = 13'h0f52;
            4'h2: t = 13'h0eac;
            4'h3: t = 13'h0e0d;
            4'h4: t = 13'h0d74;
            4'h5: t = 13'h0ce2;
            4'h6: t = 13'h0c56;
            4'h7: t = 13'h0bd1;
            4'h8: t = 13'h0b50;
            4'h9: t = 13'h0ad6;
            4'ha: t = 13'h0a60;
            4'hb: t = 13'h09ef;
            4'hc: t = 13'h0983;
            4'hd: t = 13'h091c;
            4'he: t = 13'h08b9;
            default: t = 13'h085b;
        endcase
        return t;
    endfunction

    logic signed [63:0] prodDc;
    logic signed [63:0] prodSq;
    logic signed [63:0] prodLog;
    logic signed [31:0] expArg;
    logic signed [31:0] log2Arg;
    logic signed [63:0] rampNum;
    logic signed [63:0] rampDen;
    logic signed [63:0] rampQ;
    logic [12:0] expF;
    logic [12:0] rampF;

    always_comb begin
        prodDc = density * coord;
        prodSq = $signed(prodDc[47:16]) * $signed(prodDc[47:16]);
        expArg = (equation == fhb_pkg::EQ_DECAY_SQUARED) ? prodSq[47:16] : prodDc[47:16];
        prodLog = expArg * fhb_pkg::LOG2E_Q16;
        log2Arg = prodLog[47:16];
        // Exponent of two split into whole shift and table lookup.
        if (expArg <= fhb_pkg::PARAM_ZERO) begin
            expF = fhb_pkg::F_ONE;
        end else if (log2Arg[31:16] > 16'(fhb_pkg::F_FRAC)) begin
            expF = '0;
        end else begin
            expF = pow2Frac(log2Arg[15:12]) >> log2Arg[19:16];
        end
        rampNum = 64'(hazeEnd - coord) <<< fhb_pkg::F_FRAC;
        rampDen = 64'(hazeEnd - hazeStart);
        // End equal to start is undefined; returning unity avoids a divide by zero.
        // The unity value is made signed so the quotient stays a signed division.
        rampQ = (rampDen == '0) ? $signed(64'(fhb_pkg::F_ONE)) : rampNum / rampDen;
        if (rampQ < 0) begin
            rampF = '0;
        end else if (rampQ > 64'(fhb_pkg::F_ONE)) begin
            rampF = fhb_pkg::F_ONE;
        end else begin
            rampF = rampQ[12:0];
        end
        factor = (equation == fhb_pkg::EQ_RAMP_FALLOFF) ? rampF : expF;
    end
endmodule

// ==== src/fhb_pkg.sv ====
package fhb_pkg;
    typedef enum logic [1:0] {
        EQ_DECAY_SINGLE,
        EQ_DECAY_SQUARED,
        EQ_RAMP_FALLOFF
    } fhb_equation_t;

    // Register bus.
    localparam int ADDR_W = 6;
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_EQUATION = 6'h04;
    localparam logic [5:0] REG_DENSITY = 6'h08;
    localparam logic [5:0] REG_START = 6'h0c;
    localparam logic [5:0] REG_END = 6'h10;
    localparam logic [5:0] REG_COLOR_R = 6'h14;
    localparam logic [5:0] REG_COLOR_G = 6'h18;
    localparam logic [5:0] REG_COLOR_B = 6'h1c;
    localparam logic [5:0] REG_COLOR_A = 6'h20;
    localparam logic [5:0] REG_INDEX = 6'h24;
    localparam logic [5:0] REG_STATUS = 6'h28;

    // Field positions.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SOURCE_BIT = 1;
    localparam int STAT_ERROR_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int COLOR_INT_FLAG_BIT = 31;

    // Source select codes.
    localparam logic SRC_EYE_DISTANCE = 1'h0;
    localparam logic SRC_HAZE_COORD = 1'h1;

    // Parameters are signed Q16.16, colours signed Q4.12, f unsigned Q1.12.
    localparam int PARAM_FRAC = 16;
    localparam int F_FRAC = 12;
    localparam int F_W = 13;
    localparam logic [12:0] F_ONE = 13'h1000;
    localparam logic [12:0] F_HALF = 13'h0800;
    localparam logic signed [15:0] COLOR_ONE = 16'sh1000;
    localparam logic signed [31:0] PARAM_ONE = 32'sh0001_0000;
    localparam logic signed [31:0] PARAM_ZERO = 32'sh0000_0000;
    localparam logic signed [31:0] LOG2E_Q16 = 32'sh0001_7154;

    // Colour index: n integer bits over IDX_FRAC fraction bits.
    localparam int IDX_INT = 8;
    localparam int IDX_FRAC = 4;
    localparam int IDX_W = 16;
    localparam logic [15:0] IDX_INT_MASK = 16'h0fff;
endpackage

// ==== tb/fhb_blend_unit_bench.sv ====
`timescale 1ns/100ps
module fhb_blend_unit_bench;
    logic clk = 0, sys_rst = 1, regWrStrobe = 0, regRdStrobe = 0, fragReady, outValid, fragValid;
    logic geomShaderActive = 0, fragShaderActive = 0, indexMode = 0, colorClampEnable = 0;
    logic fragUseVertexFactor;
    logic [5:0] regAddr = 0;
    logic [31:0] regWrData = 0, regRdData, fragEyeZ, fragHazeCoord;
    logic [15:0] fragRed, fragGreen, fragBlue, fragAlpha, fragIndex, outIndex;
    logic signed [15:0] outRed, outGreen, outBlue, outAlpha;
    logic [12:0] fragVertexFactor;
    int num_errors = 0, n_compared = 0;
    localparam logic [31:0] RST [11] = '{0, 0, 32'h0001_0000, 0, 32'h0001_0000, 0, 0, 0, 0, 0, 0};
    fhb_blend_unit DUT (.clk, .sys_rst, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe,
        .regRdData, .fragValid, .fragReady, .fragRed, .fragGreen, .fragBlue, .fragAlpha,
        .fragIndex, .fragEyeZ, .fragHazeCoord, .fragVertexFactor, .fragUseVertexFactor,
        .geomShaderActive, .fragShaderActive, .indexMode, .colorClampEnable, .outValid,
        .outRed, .outGreen, .outBlue, .outAlpha, .outIndex);
    fhb_raster_model src (.clk, .fragReady, .fragValid, .fragRed, .fragGreen, .fragBlue,
        .fragAlpha, .fragIndex, .fragEyeZ, .fragHazeCoord, .fragVertexFactor,
        .fragUseVertexFactor);
    initial begin
        forever #5 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        {regAddr, regWrData, regWrStrobe} <= {a, d, 1'b1};
        @(posedge clk);
        regWrStrobe <= 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        @(posedge clk);
        {regAddr, regRdStrobe} <= {a, 1'b1};
        @(posedge clk);
        regRdStrobe <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, regRdData);
    endtask
    // Sends one fragment and judges the single result cycle three edges on.
    task fr(input logic [15:0] c, input logic [31:0] z, h, input logic [12:0] v,
        input logic u, input logic [15:0] er, eg, eb);
        src.send(c, z, h, v, u);
        repeat (2) @(posedge clk);
        #1;
        chk("valid", 1, outValid);
        chk("alpha", 16'h0C00, outAlpha);
        if (indexMode) chk("index", er, outIndex);
        else begin
            chk("red", er, outRed);
            chk("green", eg, outGreen);
            chk("blue", eb, outBlue);
        end
    endtask
    task t_reset;
        for (int i = 0; i < 11; i++) rd(6'(4 * i), RST[i]);
        wr(6'h2C, 32'h1234_5678);
        rd(6'h2C, 0);
    endtask
    task t_regs;
        wr(fhb_pkg::REG_COLOR_R, 32'h8000_00FF);
        rd(fhb_pkg::REG_COLOR_R, 32'h0000_1000);
        wr(fhb_pkg::REG_COLOR_G, 32'h0000_0800);
        rd(fhb_pkg::REG_COLOR_G, 32'h0000_0800);
        wr(fhb_pkg::REG_INDEX, 32'h0000_F123);
        rd(fhb_pkg::REG_INDEX, 32'h0000_0123);
        wr(fhb_pkg::REG_START, 32'h0000_8000);
        rd(fhb_pkg::REG_START, 32'h0000_8000);
        rd(fhb_pkg::REG_END, 32'h0001_0000);
        wr(fhb_pkg::REG_START, 0);
        wr(fhb_pkg::REG_DENSITY, 32'hFFFF_0000);
        rd(fhb_pkg::REG_DENSITY, 32'h0001_0000);
        rd(fhb_pkg::REG_STATUS, 1);
        wr(fhb_pkg::REG_STATUS, 1);
        rd(fhb_pkg::REG_STATUS, 0);
        for (int q = 0; q < 3; q++) begin
            wr(fhb_pkg::REG_EQUATION, q);
            rd(fhb_pkg::REG_EQUATION, q);
        end
        wr(fhb_pkg::REG_EQUATION, 3);
        rd(fhb_pkg::REG_EQUATION, 2);
        wr(fhb_pkg::REG_STATUS, 1);
        wr(fhb_pkg::REG_EQUATION, 0);
    endtask
    task t_blend;
        fr(16'h0400, 0, 0, 0, 1, 16'h0400, 16'h0400, 16'h0400);
        wr(fhb_pkg::REG_CTRL, 1);
        @(posedge clk) fragShaderActive <= 1'b1;
        fr(16'h0400, 0, 0, 0, 1, 16'h0400, 16'h0400, 16'h0400);
        @(posedge clk) fragShaderActive <= 1'b0;
        fr(16'h0400, 0, 0, 0, 1, 16'h1000, 16'h0800, 16'h0000);
        fr(16'h0400, 0, 0, 13'h0800, 1, 16'h0A00, 16'h0600, 16'h0200);
        fr(16'h0400, 0, 0, 13'h1FFF, 1, 16'h0400, 16'h0400, 16'h0400);
        @(posedge clk) colorClampEnable <= 1'b1;
        fr(16'h2000, 0, 0, 13'h1000, 1, 16'h1000, 16'h1000, 16'h1000);
        @(posedge clk) colorClampEnable <= 1'b0;
    endtask
    task t_ramp;
        wr(fhb_pkg::REG_EQUATION, 2);
        wr(fhb_pkg::REG_END, 32'h0002_0000);
        fr(16'h0400, 32'hFFFF_0000, 0, 0, 0, 16'h0A00, 16'h0600, 16'h0200);
        fr(16'h0400, 32'hFFFE_0000, 0, 0, 0, 16'h1000, 16'h0800, 16'h0000);
        @(posedge clk) geomShaderActive <= 1'b1;
        fr(16'h0400, 32'hFFFE_0000, 0, 0, 0, 16'h0400, 16'h0400, 16'h0400);
        @(posedge clk) geomShaderActive <= 1'b0;
        wr(fhb_pkg::REG_CTRL, 3);
        fr(16'h0400, 0, 32'h0003_0000, 0, 0, 16'h1000, 16'h0800, 16'h0000);
        wr(fhb_pkg::REG_EQUATION, 1);
        fr(16'h0400, 0, 32'h0004_0000, 0, 0, 16'h1000, 16'h0800, 16'h0000);
        wr(fhb_pkg::REG_EQUATION, 0);
        fr(16'h0400, 0, 32'h0010_0000, 0, 0, 16'h1000, 16'h0800, 16'h0000);
    endtask
    task t_index;
        wr(fhb_pkg::REG_CTRL, 1);
        @(posedge clk) indexMode <= 1'b1;
        fr(16'h0400, 0, 0, 0, 1, 16'h0033, 0, 0);
        @(posedge clk) indexMode <= 1'b0;
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_regs;
        t_blend;
        t_ramp;
        t_index;
        print_verdict;
    end
    // The sequence needs well under a thousand cycles; this only cuts a hang short.
    initial begin
        #30000;
        num_errors++;
        print_verdict;
    end
endmodule

// ==== tb/fhb_blend_unit_chk.sv ====
`timescale 1ns/100ps
module fhb_blend_unit_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Register port.
    input wire logic regRdStrobe,
    input wire logic [31:0] regRdData,
    // Fragment input and pipeline mode inputs.
    input wire logic fragValid,
    input wire logic fragReady,
    input wire logic signed [15:0] fragRed,
    input wire logic signed [15:0] fragAlpha,
    input wire logic [12:0] fragVertexFactor,
    input wire logic fragUseVertexFactor,
    input wire logic fragShaderActive,
    input wire logic indexMode,
    input wire logic colorClampEnable,
    // Fragment output.
    input wire logic outValid,
    input wire logic signed [15:0] outRed,
    input wire logic signed [15:0] outAlpha,
    input wire logic [15:0] outIndex
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // An accepted fragment is the cause of every output three edges later.
    logic taken;
    assign taken = fragValid & fragReady;
    property p_ready_rise; $fell(sys_rst) |-> !fragReady ##1 fragReady; endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready late after reset");
    property p_ready_hold; fragReady |=> fragReady; endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
    property p_latency; taken |-> ##3 outValid; endproperty
    a_latency: assert property (p_latency) else $error("result missing");
    property p_no_extra; outValid |-> $past(taken, 3); endproperty
    a_no_extra: assert property (p_no_extra) else $error("result without fragment");
    property p_bypass; taken && fragShaderActive |-> ##3 outRed == $past(fragRed, 3); endproperty
    a_bypass: assert property (p_bypass) else $error("shader bypass altered red");
    property p_alpha; taken && !colorClampEnable |-> ##3 outAlpha == $past(fragAlpha, 3); endproperty
    a_alpha: assert property (p_alpha) else $error("alpha changed");
    property p_unit;
        taken && fragUseVertexFactor && fragVertexFactor >= fhb_pkg::F_ONE && !indexMode
            && !colorClampEnable |-> ##3 outRed == $past(fragRed, 3);
    endproperty
    a_unit: assert property (p_unit) else $error("factor above one not clamped");
    property p_index_mask; outValid && indexMode |-> outIndex[15:12] == 4'h0; endproperty
    a_index_mask: assert property (p_index_mask) else $error("index not masked");
    property p_rd_idle; regRdData != 32'h0000_0000 |-> $past(regRdStrobe); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule
bind fhb_blend_unit fhb_blend_unit_chk u_chk (.clk, .sys_rst, .regRdStrobe, .regRdData,
    .fragValid, .fragReady, .fragRed, .fragAlpha, .fragVertexFactor, .fragUseVertexFactor,
    .fragShaderActive, .indexMode, .colorClampEnable, .outValid, .outRed, .outAlpha, .outIndex);

// ==== tb/fhb_raster_model.sv ====
`timescale 1ns/100ps
module fhb_raster_model (
    // Clock and handshake.
    input wire logic clk,
    input wire logic fragReady,
    output logic fragValid,
    // Fragment data.
    output logic [15:0] fragRed,
    output logic [15:0] fragGreen,
    output logic [15:0] fragBlue,
    output logic [15:0] fragAlpha,
    output logic [15:0] fragIndex,
    output logic [31:0] fragEyeZ,
    output logic [31:0] fragHazeCoord,
    output logic [12:0] fragVertexFactor,
    output logic fragUseVertexFactor
);
    initial begin
        {fragValid, fragRed, fragGreen, fragBlue, fragAlpha, fragIndex} = '0;
        {fragEyeZ, fragHazeCoord, fragVertexFactor, fragUseVertexFactor} = '0;
    end
    // Colour goes to R, G and B alike; alpha and index are fixed markers.
    task send(input logic [15:0] c, input logic [31:0] z, h, input logic [12:0] v,
        input logic u);
        @(posedge clk);
        fragValid <= 1'b1;
        {fragRed, fragGreen, fragBlue, fragAlpha, fragIndex} <= {c, c, c, 16'h0C00, 16'h0F10};
        {fragEyeZ, fragHazeCoord} <= {z, h};
        fragVertexFactor <= v;
        fragUseVertexFactor <= u;
        do @(posedge clk); while (!fragReady);
        // Released colour, eye Z and haze coordinate are scrambled so nothing downstream can lean on their stale values.
        fragValid <= 1'b0;
        {fragRed, fragGreen, fragBlue, fragEyeZ, fragHazeCoord} <= ~{c, c, c, z, h};
    endtask
endmodule
